// >>> pkg/rfc_map.svh
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH

// ********************************
// Register offsets
// ********************************
`define RFC_A_FLAGS   8'h00
`define RFC_A_ISTAT   8'h01
`define RFC_A_ICLR    8'h02
`define RFC_A_IEN     8'h03
`define RFC_A_TIME0   8'h04
`define RFC_A_TIME1   8'h05
`define RFC_A_TIME2   8'h06
`define RFC_A_TIME3   8'h07

// ********************************
// Flags register bit positions
// ********************************
`define RFC_B_WDOG    7
`define RFC_B_ALRM    6
`define RFC_B_SUPL    5
`define RFC_B_OSCFT   4
`define RFC_B_BKUP    3
`define RFC_B_CAL     2
`define RFC_B_W       1
`define RFC_B_R       0

// Event bits used by status, clear and enable registers
`define RFC_IRQ_MASK  8'hf8
`define RFC_ZERO8     8'h00

// ********************************
// Timing
// ********************************
`define RFC_CLK_HZ    250000000
`define RFC_SQ_HZ     512
// Half period of the calibration wave, rounded down
`define RFC_SQ_HALF   (`RFC_CLK_HZ / (2 * `RFC_SQ_HZ))
`define RFC_SQ_W      18

`endif

// >>> pkg/rfc_pkg.sv
package rfc_pkg;

   typedef logic [3:0][7:0] rfc_time_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rfc_bus_s;

   typedef struct packed {
      logic       wdog;
      logic       alarm;
      logic       sup_loss;
      logic       osc_fault;
      logic       bk_fail;
      logic       cal;
      logic       w;
      logic       r;
   } rfc_flags_s;

   typedef struct packed {
      rfc_flags_s flg;
      logic [7:0] istat;
      logic [7:0] ien;
      rfc_time_t  utime;
      rfc_time_t  load_val;
      logic       load;
      logic [7:0] rdata;
      logic       started;
      logic       sup_low_d;
   } rfc_st_s;

   typedef struct packed {
      logic [17:0] cnt;
      logic        wave;
   } rfc_sq_s;

endpackage

// >>> hw/rfc_sqwave.sv
`include "rfc_map.svh"

module rfc_sqwave #(
   parameter logic [17:0] HALF = 18'(`RFC_SQ_HALF)
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Control
   input  wire logic enable,
   // Wave
   output      logic wave
);

   rfc_pkg::rfc_sq_s st_r;
   rfc_pkg::rfc_sq_s st_nxt;

   // ********************************
   // Divider
   // ********************************
   // Held at zero while idle so each enable starts on a clean low half
   always_comb begin
      st_nxt = st_r;
      if (!enable) begin
         st_nxt.cnt  = '0;
         st_nxt.wave = 1'b0;
      end else if (st_r.cnt == HALF - 18'h1) begin
         st_nxt.cnt  = '0;
         st_nxt.wave = ~st_r.wave;
      end else begin
         st_nxt.cnt = st_r.cnt + 18'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wave = st_r.wave;

endmodule // rfc_sqwave

// >>> hw/rfc_flags.sv
`include "rfc_map.svh"

// Functional notes
// - Alarm flag sets when time matches alarm in every unmasked field.
// - Alarm flag clears on a flags read and at power-up.
// - Oscillator fault sets at power-up on backup failure; hardware never clears it.
// - Calibration bit drives 512 Hz onto interrupt pin, overriding normal use.
// - Write-freeze stops user clock updates and opens clock writes.
// - Releasing write-freeze loads written clock into counters; zero at power-up.
// - Read-hold freezes user clock copy for a stable read; zero at power-up.
// - Read-hold works whatever the write-freeze bit is.
module rfc_flags #(
   parameter logic [17:0] SQ_HALF = 18'(`RFC_SQ_HALF)
) (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output      logic [7:0]         reg_rdata,
   // Time-keeping counters
   input  wire rfc_pkg::rfc_time_t cnt_time,
   input  wire logic               cnt_tick,
   output      logic               cnt_load,
   output      rfc_pkg::rfc_time_t cnt_load_val,
   // Alarm registers
   input  wire rfc_pkg::rfc_time_t alarm_val,
   input  wire logic [3:0]         alarm_mask,
   // Supply and watchdog events
   input  wire logic               supply_low,
   input  wire logic               backup_fail,
   input  wire logic               wdt_zero,
   // Pins and side-band
   input  wire logic               int_normal,
   output      logic               int_pin,
   output      logic               clk_write_open,
   output      logic               irq
);

   rfc_pkg::rfc_st_s  st_r;
   rfc_pkg::rfc_st_s  st_nxt;
   rfc_pkg::rfc_bus_s bus;
   logic [3:0]        fld_ok;
   logic              alarm_hit;
   logic              flags_rd;
   logic              flags_wr;
   logic              sup_rise;
   logic [7:0]        set_vec;
   logic [7:0]        flags_q;
   logic              wave;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ********************************
   // Alarm compare
   // ********************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_fld
         assign fld_ok[gi] = alarm_mask[gi] || (cnt_time[gi] == alarm_val[gi]);
      end
   endgenerate

   // Checked only on a counter step, so one match sets the flag once
   assign alarm_hit = cnt_tick && (&fld_ok);
   assign flags_rd  = bus.rd && (bus.addr == `RFC_A_FLAGS);
   assign flags_wr  = bus.wr && (bus.addr == `RFC_A_FLAGS);
   assign sup_rise  = supply_low && !st_r.sup_low_d;
   assign flags_q   = st_r.flg;

   // ********************************
   // Next state
   // ********************************
   always_comb begin
      st_nxt           = st_r;
      st_nxt.load      = 1'b0;
      st_nxt.sup_low_d = supply_low;
      st_nxt.rdata     = `RFC_ZERO8;
      set_vec          = `RFC_ZERO8;

      // Read data and read side effects; a set in the same cycle wins
      if (bus.rd) begin
         unique case (bus.addr)
            `RFC_A_FLAGS: st_nxt.rdata = flags_q;
            `RFC_A_ISTAT: st_nxt.rdata = st_r.istat;
            `RFC_A_IEN:   st_nxt.rdata = st_r.ien;
            `RFC_A_TIME0, `RFC_A_TIME1, `RFC_A_TIME2, `RFC_A_TIME3: st_nxt.rdata = st_r.utime[bus.addr[1:0]];
            default:      st_nxt.rdata = `RFC_ZERO8;
         endcase
      end
      if (flags_rd) begin
         st_nxt.flg.alarm    = 1'b0;
         st_nxt.flg.sup_loss = 1'b0;
         st_nxt.flg.wdog     = 1'b0;
         st_nxt.flg.bk_fail  = 1'b0;
      end

      // Control bits; oscillator fault only falls by a software zero
      if (flags_wr) begin
         st_nxt.flg.cal = bus.wdata[`RFC_B_CAL];
         st_nxt.flg.w   = bus.wdata[`RFC_B_W];
         st_nxt.flg.r   = bus.wdata[`RFC_B_R];
         if (!bus.wdata[`RFC_B_OSCFT]) begin
            st_nxt.flg.osc_fault = 1'b0;
         end
      end

      // Hardware events
      if (alarm_hit) begin
         st_nxt.flg.alarm     = 1'b1;
         set_vec[`RFC_B_ALRM] = 1'b1;
      end
      if (sup_rise) begin
         st_nxt.flg.sup_loss  = 1'b1;
         set_vec[`RFC_B_SUPL] = 1'b1;
      end
      if (wdt_zero) begin
         st_nxt.flg.wdog      = 1'b1;
         set_vec[`RFC_B_WDOG] = 1'b1;
      end

      // Backup state caught once, the first cycle after reset release
      if (!st_r.started) begin
         st_nxt.started = 1'b1;
         if (backup_fail) begin
            st_nxt.flg.osc_fault  = 1'b1;
            st_nxt.flg.bk_fail    = 1'b1;
            set_vec[`RFC_B_OSCFT] = 1'b1;
            set_vec[`RFC_B_BKUP]  = 1'b1;
         end
      end

      // User clock copy: frozen by either bit, written only while frozen for write
      if (st_r.flg.w) begin
         if (bus.wr && (bus.addr >= `RFC_A_TIME0) && (bus.addr <= `RFC_A_TIME3)) begin
            st_nxt.utime[bus.addr[1:0]] = bus.wdata;
         end
      end else if (!st_r.flg.r) begin
         st_nxt.utime = cnt_time;
      end

      // Commit on release of write-freeze
      if (st_r.flg.w && !st_nxt.flg.w) begin
         st_nxt.load     = 1'b1;
         st_nxt.load_val = st_r.utime;
      end

      // Interrupt status: clear by writing ones, a new event wins
      if (bus.wr && (bus.addr == `RFC_A_ICLR)) begin
         st_nxt.istat = st_r.istat & ~bus.wdata;
      end
      if (bus.wr && (bus.addr == `RFC_A_IEN)) begin
         st_nxt.ien = bus.wdata & `RFC_IRQ_MASK;
      end
      st_nxt.istat = (st_nxt.istat | set_vec) & `RFC_IRQ_MASK;
   end

   // ********************************
   // State register
   // ********************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************
   // Calibration wave and outputs
   // ********************************
   rfc_sqwave #(
      .HALF (SQ_HALF)
   ) u_sq (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .enable  (st_r.flg.cal),
      .wave    (wave)
   );

   // Pin muxes the flopped wave with the unregistered int_normal input, under a flopped select
   assign int_pin        = st_r.flg.cal ? wave : int_normal;
   assign reg_rdata      = st_r.rdata;
   assign cnt_load       = st_r.load;
   assign cnt_load_val   = st_r.load_val;
   assign clk_write_open = st_r.flg.w;
   assign irq            = |(st_r.istat & st_r.ien);

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   logic time_wr;
   assign time_wr = bus.wr && (bus.addr >= `RFC_A_TIME0) && (bus.addr <= `RFC_A_TIME3);

   alarm_set_a: assert property (alarm_hit |=> st_r.flg.alarm)
      else $error("alarm flag not set on match");

   alarm_nomatch_a: assert property (
      (!st_r.flg.alarm && !alarm_hit) |=> !st_r.flg.alarm)
      else $error("alarm flag set without match");

   alarm_rdclr_a: assert property (
      (flags_rd && !alarm_hit) |=> (!st_r.flg.alarm ##1 st_r.rdata[`RFC_B_ALRM] == 1'b0))
      else $error("alarm flag survived flags read");

   osc_keep_a: assert property (
      (st_r.flg.osc_fault && !(flags_wr && !bus.wdata[`RFC_B_OSCFT])) |=> st_r.flg.osc_fault)
      else $error("oscillator fault cleared by hardware");

   osc_capture_a: assert property (
      (!st_r.started && backup_fail) |=> (st_r.flg.osc_fault && st_r.started))
      else $error("oscillator fault not caught at start");

   cal_pass_a: assert property (!st_r.flg.cal |-> (int_pin == int_normal))
      else $error("interrupt pin not in normal use");

   cal_wave_a: assert property (
      $rose(st_r.flg.cal) |-> (int_pin == 1'b0)[*8])
      else $error("calibration wave did not start low");

   freeze_time_a: assert property (
      (st_r.flg.w && !time_wr) |=> $stable(st_r.utime))
      else $error("user clock moved during write freeze");

   commit_load_a: assert property (
      $fell(st_r.flg.w) |-> (cnt_load && (cnt_load_val == $past(st_r.utime))))
      else $error("written clock not committed");

   load_once_a: assert property (cnt_load |=> !cnt_load)
      else $error("commit pulse longer than one cycle");

   hold_read_a: assert property (
      (st_r.flg.r && !st_r.flg.w) |=> $stable(st_r.utime))
      else $error("user clock moved during read hold");

   resume_copy_a: assert property (
      (!st_r.flg.r && !st_r.flg.w) |=> (st_r.utime == $past(cnt_time)))
      else $error("user clock not following counters");

   hold_any_w_a: assert property (
      (flags_wr && bus.wdata[`RFC_B_R]) |=> st_r.flg.r)
      else $error("read hold not honoured");

   supply_set_a: assert property (sup_rise |=> (st_r.flg.sup_loss && st_r.istat[`RFC_B_SUPL]))
      else $error("supply loss flag not set");

   // A read in the cycle after the set may clear it legally
   wdt_set_a: assert property (
      wdt_zero |=> st_r.flg.wdog ##1 ($past(flags_rd) || st_r.flg.wdog))
      else $error("watchdog flag not set or lost");

   wdt_rdclr_a: assert property ((flags_rd && !wdt_zero) |=> !st_r.flg.wdog)
      else $error("watchdog flag survived flags read");

   irq_level_a: assert property (
      (st_r.ien[`RFC_B_ALRM] && alarm_hit) |=> ##1 irq)
      else $error("enabled alarm did not raise interrupt");

   alarm_c: cover property (alarm_hit ##1 flags_rd);
   commit_c: cover property (time_wr ##[1:20] cnt_load);
   cal_c: cover property ($rose(st_r.flg.cal) ##[1:100] $fell(st_r.flg.cal));
   hold_c: cover property (st_r.flg.r && cnt_tick);

endmodule // rfc_flags

// >>> verification/rfc_time_model.sv
module rfc_time_model (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   // Load request
   input  wire logic               cnt_load,
   input  wire rfc_pkg::rfc_time_t cnt_load_val,
   // Counter state
   output      rfc_pkg::rfc_time_t cnt_time,
   output      logic               cnt_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_r;
   // Fast tick, so frozen copies visibly fall behind
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         div_r <= 3'h0;
         cnt_time <= '0;
         cnt_tick <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         cnt_tick <= (div_r == 3'h7);
         if (cnt_load) begin
            cnt_time <= cnt_load_val;
         end else if (div_r == 3'h7) begin
            cnt_time <= cnt_time + 32'h1;
         end
      end
   end
endmodule // rfc_time_model

// >>> verification/tb_rfc_flags.sv
`include "rfc_map.svh"
module tb_rfc_flags;
   timeunit 1ns;
   timeprecision 1ps;
   logic               ref_clk, resetn, reg_wr, reg_rd, cnt_tick, cnt_load;
   logic               supply_low, backup_fail, wdt_zero, int_normal, int_pin, clk_write_open, irq;
   logic [7:0]         reg_addr, reg_wdata, reg_rdata, v, s, m;
   logic [3:0]         alarm_mask;
   rfc_pkg::rfc_time_t cnt_time, cnt_load_val, alarm_val;
   int                 fails, n_checks, seed, hi;

   rfc_flags #(.SQ_HALF(18'h8)) uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cnt_time(cnt_time), .cnt_tick(cnt_tick), .cnt_load(cnt_load), .cnt_load_val(cnt_load_val),
      .alarm_val(alarm_val), .alarm_mask(alarm_mask), .supply_low(supply_low),
      .backup_fail(backup_fail), .wdt_zero(wdt_zero), .int_normal(int_normal), .int_pin(int_pin),
      .clk_write_open(clk_write_open), .irq(irq));
   rfc_time_model tm (.ref_clk(ref_clk), .resetn(resetn), .cnt_load(cnt_load),
      .cnt_load_val(cnt_load_val), .cnt_time(cnt_time), .cnt_tick(cnt_tick));

   // ****************************
   // Clock and bus tasks
   // ****************************
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      fails++;
      final_report();
   end

   // ****************************
   // Tests
   // ****************************
   initial begin
      seed = 8;
      {reg_addr, reg_wdata, reg_wr, reg_rd, resetn} = '0;
      {supply_low, wdt_zero, int_normal, alarm_mask} = '0;
      backup_fail = 1'b1;
      alarm_val = '1;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      backup_fail <= 1'b0;
      // Model of the flags register
      m = 8'h00;
      m[`RFC_B_OSCFT] = 1'b1;
      m[`RFC_B_BKUP] = 1'b1;
      rd(`RFC_A_FLAGS, v); chk("flags", v, m);
      m[`RFC_B_BKUP] = 1'b0;
      rd(`RFC_A_FLAGS, v); chk("flags", v, m);
      $display("test power_up done");

      wr(`RFC_A_IEN, 8'h40);
      alarm_mask <= 4'hf;
      @(posedge ref_clk iff cnt_tick);
      alarm_mask <= 4'h0;
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", irq, 1'b1);
      rd(`RFC_A_FLAGS, v); chk("flags", v, m | 8'h40);
      rd(`RFC_A_FLAGS, v); chk("flags", v, m);
      wr(`RFC_A_ICLR, 8'h40);
      @(posedge ref_clk);
      #1 chk("irq", irq, 1'b0);
      $display("test alarm done");

      @(posedge ref_clk);
      supply_low <= 1'b1;
      wdt_zero <= 1'b1;
      @(posedge ref_clk);
      wdt_zero <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk("irq", irq, 1'b0);
      // Power-up fault events are still pending in status
      rd(`RFC_A_ISTAT, v); chk("istat", v, 8'hb8);
      rd(`RFC_A_FLAGS, v); chk("flags", v, m | 8'ha0);
      rd(`RFC_A_FLAGS, v); chk("flags", v, m);
      wr(`RFC_A_ICLR, 8'hf8);
      supply_low <= 1'b0;
      $display("test events done");

      wr(`RFC_A_FLAGS, 8'h14);
      hi = 0;
      repeat (32) begin
         @(posedge ref_clk);
         int_normal <= 1'($random(seed));
         #1 hi += int_pin;
      end
      chk("wave_high", hi, 16);
      wr(`RFC_A_FLAGS, 8'h10);
      repeat (8) begin
         @(posedge ref_clk);
         int_normal <= 1'($random(seed));
         #1 chk("int_pin", int_pin, int_normal);
      end
      $display("test calibration done");

      wr(`RFC_A_FLAGS, 8'h12);
      #1 chk("open", clk_write_open, 1'b1);
      s = 8'($random(seed));
      wr(`RFC_A_TIME0, s);
      repeat (12) @(posedge ref_clk);
      rd(`RFC_A_TIME0, v); chk("time0", v, s);
      wr(`RFC_A_FLAGS, 8'h10);
      #1 chk("load", cnt_load, 1'b1);
      chk("load_val", cnt_load_val[0], s);
      @(posedge ref_clk);
      #1 chk("load", cnt_load, 1'b0);
      $display("test write_freeze done");

      wr(`RFC_A_FLAGS, 8'h13);
      wr(`RFC_A_FLAGS, 8'h11);
      rd(`RFC_A_TIME0, s);
      repeat (20) @(posedge ref_clk);
      rd(`RFC_A_TIME0, v); chk("time0", v, s);
      wr(`RFC_A_FLAGS, 8'h10);
      @(posedge ref_clk iff cnt_tick);
      #1 s = cnt_time[0];
      rd(`RFC_A_TIME0, v); chk("time0", v, s);
      $display("test read_hold done");

      rd(8'h20, v); chk("unmapped", v, 8'h00);
      wr(8'h20, 8'($random(seed)));
      rd(`RFC_A_IEN, v); chk("ien", v, 8'h40);
      $display("test map done");
      final_report();
   end
endmodule // tb_rfc_flags
